// ===== core/isc_collector.sv
// Interrupt status collector: event capture, status, mask and power wake
//
// Behaviour
// - Writing one clears that status bit
// - Software flag set while enable high
// - Transmit halted flag after stop and halt
// - Receive halted flag on receiver halt
// - Drop counter half flag at midpoint step
// - Completion flag when marked buffer loaded
// - Receive DMA flag when count drained
// - Timer flag when timer wraps to ffff
// - PHY flag read-only, writes ignored
// - Only byte test write wakes device
// - Power interrupt bypasses deassertion hold-off
// - Status FIFO overflow sets flag
// - Oversized received packet sets watchdog flag
// - Receiver and transmitter errors set flags
// - Write to full data FIFO flags overrun
// - Free space above level sets flag
// - Status FIFOs full set their flags
// - Status FIFO levels exceeded set flags
// - Every dropped frame sets flag
// - Three pin event flags, write-one-clear
// - Status recorded regardless of enable mask
// - Master indication when enabled flag active
`timescale 1ns/1ps
module isc_collector (
   input wire logic core_clk,
   input wire logic resetn,

   // Register port
   input wire logic [isc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [isc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [isc_pkg::DATA_W-1:0] reg_rdata,

   // Transmit engine
   input wire logic tx_stop_request,
   input wire logic tx_halted,
   input wire logic tx_buffer_loaded,
   input wire logic irq_on_completion,
   input wire logic tx_error,
   input wire logic tx_data_write,
   input wire logic tx_data_full,
   input wire logic [7:0] tx_free_blocks,
   input wire logic [7:0] tx_space_level,
   input wire logic tx_status_full,
   input wire logic tx_status_overflow,
   input wire logic [7:0] tx_status_used,
   input wire logic [7:0] tx_status_level,

   // Receive engine
   input wire logic rx_halted,
   input wire logic rx_dma_done,
   input wire logic rx_long_frame,
   input wire logic rx_error,
   input wire logic rx_frame_dropped,
   input wire logic [31:0] rx_drop_count,
   input wire logic rx_status_full,
   input wire logic [7:0] rx_status_used,
   input wire logic [7:0] rx_status_level,

   // Timer, PHY, power management, pins
   input wire logic [15:0] timer_count,
   input wire logic phy_irq,
   input wire logic power_event,
   input wire logic [isc_pkg::PIN_W-1:0] pin_events,

   // Results
   output logic irq_pending,
   output logic irq_pending_holdoff,
   output logic irq_power_direct,
   output logic low_power
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   // Bundle to the holder
   isc_evt_if evt ();

   // Host registers

   logic [31:0] enable_r;
   logic software_irq_enable_r;
   logic low_power_r;
   logic low_power_nxt;

   // Read pipeline
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   // Counter history
   logic [31:0] drop_count_r;
   logic [15:0] timer_count_r;

   // Onset filter
   logic [isc_pkg::LEVEL_W-1:0] level_now;
   logic [isc_pkg::LEVEL_W-1:0] level_rise;

   // Event and mask vectors
   logic [31:0] set_vec;
   logic [31:0] active_vec;
   logic [31:0] power_only;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // One wire per register and strobe kind
   // Full byte address compared: no aliases
   wire hit_status = reg_addr == isc_pkg::OFS_STATUS;
   wire hit_enable = reg_addr == isc_pkg::OFS_ENABLE;
   wire hit_byte_test = reg_addr == isc_pkg::OFS_BYTE_TEST;
   // Local control word
   wire hit_control = reg_addr == isc_pkg::OFS_CONTROL;

   // Writes qualified by address
   wire wr_status = reg_wr & hit_status;
   wire wr_enable = reg_wr & hit_enable;
   wire wr_byte_test = reg_wr & hit_byte_test;
   wire wr_control = reg_wr & hit_control;

   // ----------------------------------------------------------------
   // Level conditions watched for their onset
   // ----------------------------------------------------------------
   // A level condition flags once per onset, so a host clear of a
   // persisting condition is not immediately undone.
   // Limitation: a level high at reset
   // release flags on the first edge.
   // Thresholds are strictly above level.
   assign level_now[0] = tx_stop_request & tx_halted;
   assign level_now[1] = rx_halted;
   assign level_now[2] = isc_pkg::above_level(tx_free_blocks, tx_space_level);
   assign level_now[3] = tx_status_full;
   assign level_now[4] = isc_pkg::above_level(tx_status_used, tx_status_level);
   assign level_now[5] = rx_status_full;
   assign level_now[6] = isc_pkg::above_level(rx_status_used, rx_status_level);

   // One detector, seven conditions
   isc_rise_detect u_rise (
      .core_clk(core_clk),
      .resetn(resetn),
      .level_in(level_now),
      .rise_out(level_rise)
   );

   // ----------------------------------------------------------------
   // History of counters that flag on a particular step
   // ----------------------------------------------------------------
   // Timer history starts at its own reset value so release is no wrap.
   // Drop history starts far from the
   // midpoint, so no false step either.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         drop_count_r <= 32'h0000_0000;
         timer_count_r <= isc_pkg::TIMER_WRAPPED;
      end else begin
         // Sampled every cycle
         drop_count_r <= rx_drop_count;
         timer_count_r <= timer_count;
      end
   end

   // Counter step detection; one cycle
   // only, as the sample pair moves on
   wire drop_half_step = (drop_count_r == isc_pkg::DROP_BEFORE_HALF)
      && (rx_drop_count == isc_pkg::DROP_AT_HALF);
   wire timer_wrap_step = (timer_count_r == isc_pkg::TIMER_ZERO)
      && (timer_count == isc_pkg::TIMER_WRAPPED);

   // ----------------------------------------------------------------
   // Set vector: every source lands on its own bit
   // ----------------------------------------------------------------
   // Sources are recorded with no regard to the enable mask
   always_comb begin
      set_vec = 32'h0000_0000;

      // Software and halts
      set_vec[isc_pkg::BIT_SOFTWARE] = software_irq_enable_r;
      set_vec[isc_pkg::BIT_TX_HALTED] = level_rise[0];
      set_vec[isc_pkg::BIT_RX_HALTED] = level_rise[1];

      // Counters and completions
      set_vec[isc_pkg::BIT_DROP_HALF] = drop_half_step;
      set_vec[isc_pkg::BIT_TX_COMPLETE] = tx_buffer_loaded & irq_on_completion;
      set_vec[isc_pkg::BIT_RX_DMA] = rx_dma_done;
      set_vec[isc_pkg::BIT_TIMER_WRAP] = timer_wrap_step;

      // Power; wake output plays no part
      set_vec[isc_pkg::BIT_POWER] = power_event;

      // Errors and overflows
      set_vec[isc_pkg::BIT_TX_STS_OVF] = tx_status_overflow;
      set_vec[isc_pkg::BIT_RX_WATCHDOG] = rx_long_frame;
      set_vec[isc_pkg::BIT_RX_ERROR] = rx_error;
      set_vec[isc_pkg::BIT_TX_ERROR] = tx_error;
      set_vec[isc_pkg::BIT_TX_OVERRUN] = tx_data_write & tx_data_full;

      // FIFO onsets
      set_vec[isc_pkg::BIT_TX_SPACE] = level_rise[2];
      set_vec[isc_pkg::BIT_TX_STS_FULL] = level_rise[3];
      set_vec[isc_pkg::BIT_TX_STS_LEVEL] = level_rise[4];

      // Receive drops and status
      set_vec[isc_pkg::BIT_FRAME_DROP] = rx_frame_dropped;
      set_vec[isc_pkg::BIT_RX_STS_FULL] = level_rise[5];
      set_vec[isc_pkg::BIT_RX_STS_LEVEL] = level_rise[6];

      // Pin events
      set_vec[isc_pkg::BIT_PIN_LSB +: isc_pkg::PIN_W] = pin_events;
   end

   // ----------------------------------------------------------------
   // Status register hookup
   // ----------------------------------------------------------------
   // Only ones in clearable positions clear; zeros and the PHY bit are kept
   // Writes elsewhere never reach
   // the holder
   assign evt.set_pulse = set_vec;
   assign evt.clear_mask = wr_status ? (reg_wdata & isc_pkg::STATUS_W1C_MASK) : 32'h0000_0000;
   assign evt.phy_level = phy_irq;


   // Sticky bits, live PHY overlay
   isc_status_reg u_status (
      .core_clk(core_clk),
      .resetn(resetn),
      .evt(evt.holder)
   );

   // ----------------------------------------------------------------
   // Enable mask and control registers
   // ----------------------------------------------------------------
   // Reserved enable bits other than bit 22 never store, so they read zero
   // The PHY enable does store: the
   // live PHY level may raise the line
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         enable_r <= isc_pkg::ENABLE_RESET;
      end else if (wr_enable) begin
         // Whole word at once
         enable_r <= reg_wdata & isc_pkg::STATUS_IMPL_MASK;
      end
   end

   // Software interrupt enable; while
   // high the flag re-arms each cycle
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         software_irq_enable_r <= 1'b0;
      end else if (wr_control) begin
         // Other bits do not store
         software_irq_enable_r <= reg_wdata[isc_pkg::CTL_SW_IRQ_EN];
      end
   end

   // ----------------------------------------------------------------
   // Reduced power state
   // ----------------------------------------------------------------
   // A power event only flags; the byte test write is the sole way out.
   // Wake is checked last so a simultaneous sleep request cannot win.
   // Bus stays live while asleep,
   // or the wake write could not land.
   always_comb begin
      // Hold by default
      low_power_nxt = low_power_r;
      if (wr_control && reg_wdata[isc_pkg::CTL_SLEEP_REQ]) begin
         low_power_nxt = 1'b1;
      end
      if (wr_byte_test) begin
         low_power_nxt = 1'b0;
      end
   end

   // Power state flop
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         low_power_r <= 1'b0;
      end else begin
         low_power_r <= low_power_nxt;
      end
   end

   // Straight from the flop
   assign low_power = low_power_r;

   // ----------------------------------------------------------------
   // Interrupt indications
   // ----------------------------------------------------------------
   // The power flag is split off so the pin controller can route it
   // around its deassertion hold-off timer.
   // All three are combinational;
   // the pin controller registers them.
   // The live PHY bit counts if enabled.
   assign active_vec = evt.status & enable_r;
   assign power_only = active_vec & (32'h0000_0001 << isc_pkg::BIT_POWER);

   // Master line and its two parts
   assign irq_pending = |active_vec;
   assign irq_pending_holdoff = |(active_vec & ~power_only);
   assign irq_power_direct = |power_only;

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Unmapped addresses read zero; data stands one cycle after the strobe
   // Status is taken before that edge's
   // sets and clears land
   always_comb begin
      // Zero without a read strobe
      rdata_nxt = 32'h0000_0000;
      if (reg_rd) begin
         // Hits are exclusive
         if (hit_status) begin
            rdata_nxt = evt.status;
         end else if (hit_enable) begin
            rdata_nxt = enable_r;
         end else if (hit_byte_test) begin
            rdata_nxt = isc_pkg::BYTE_TEST_VALUE;
         end else if (hit_control) begin
            // Sleep request is write-only
            rdata_nxt[isc_pkg::CTL_SW_IRQ_EN] = software_irq_enable_r;
            rdata_nxt[isc_pkg::CTL_LOW_POWER] = low_power_r;
         end
      end
   end

   // Read data flop, zero outside the answer cycle
   // A quiet bus makes stale data
   // easy to spot
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

endmodule : isc_collector

// ===== core/isc_evt_if.sv
// Carrier between event capture and the sticky status register
`timescale 1ns/1ps
interface isc_evt_if;
   logic [31:0] set_pulse;
   logic [31:0] clear_mask;
   logic phy_level;
   logic [31:0] status;

   modport producer (output set_pulse, output clear_mask, output phy_level, input status);
   modport holder (input set_pulse, input clear_mask, input phy_level, output status);
endinterface : isc_evt_if

// ===== core/isc_pkg.sv
// Shared constants and helpers for the interrupt status collector
package isc_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_STATUS = 8'h58;
   localparam logic [7:0] OFS_ENABLE = 8'h5c;
   localparam logic [7:0] OFS_BYTE_TEST = 8'h64;
   localparam logic [7:0] OFS_CONTROL = 8'hb8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ----------------------------------------------------------------
   // Status bit positions
   // ----------------------------------------------------------------
   localparam int BIT_SOFTWARE = 31;
   localparam int BIT_TX_HALTED = 25;
   localparam int BIT_RX_HALTED = 24;
   localparam int BIT_DROP_HALF = 23;
   localparam int BIT_TX_COMPLETE = 21;
   localparam int BIT_RX_DMA = 20;
   localparam int BIT_TIMER_WRAP = 19;
   localparam int BIT_PHY = 18;
   localparam int BIT_POWER = 17;
   localparam int BIT_TX_STS_OVF = 16;
   localparam int BIT_RX_WATCHDOG = 15;
   localparam int BIT_RX_ERROR = 14;
   localparam int BIT_TX_ERROR = 13;
   localparam int BIT_TX_OVERRUN = 10;
   localparam int BIT_TX_SPACE = 9;
   localparam int BIT_TX_STS_FULL = 8;
   localparam int BIT_TX_STS_LEVEL = 7;
   localparam int BIT_FRAME_DROP = 6;
   localparam int BIT_RX_STS_FULL = 4;
   localparam int BIT_RX_STS_LEVEL = 3;
   localparam int BIT_PIN_LSB = 0;
   localparam int PIN_W = 3;

   // Sticky bits (PHY position included), and enable-storable bits (those plus reserved bit 22)
   localparam logic [31:0] STATUS_W1C_MASK = 32'h83bf_e7df;
   localparam logic [31:0] STATUS_IMPL_MASK = 32'h83ff_e7df;

   // ----------------------------------------------------------------
   // Control register fields and reset values
   // ----------------------------------------------------------------
   localparam int CTL_SW_IRQ_EN = 0;
   localparam int CTL_SLEEP_REQ = 1;
   localparam int CTL_LOW_POWER = 2;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
   localparam logic [31:0] BYTE_TEST_VALUE = 32'h8765_4321;

   // ----------------------------------------------------------------
   // Event source thresholds
   // ----------------------------------------------------------------
   localparam logic [31:0] DROP_BEFORE_HALF = 32'h7fff_ffff;
   localparam logic [31:0] DROP_AT_HALF = 32'h8000_0000;
   localparam logic [15:0] TIMER_ZERO = 16'h0000;
   localparam logic [15:0] TIMER_WRAPPED = 16'hffff;
   localparam int LEVEL_W = 7;

   // Strictly above the programmed level
   function automatic logic above_level(input logic [7:0] used, input logic [7:0] level);
      return used > level;
   endfunction : above_level

endpackage : isc_pkg

// ===== core/isc_rise_detect.sv
// Rising-edge detector for level conditions
`timescale 1ns/1ps
module isc_rise_detect (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [isc_pkg::LEVEL_W-1:0] level_in,
   output logic [isc_pkg::LEVEL_W-1:0] rise_out
);

   logic [isc_pkg::LEVEL_W-1:0] level_r;

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   // Held level alone never re-fires after a clear, only a fresh onset
   assign rise_out = level_in & ~level_r;

   // Previous level
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         level_r <= '0;
      end else begin
         level_r <= level_in;
      end
   end

endmodule : isc_rise_detect

// ===== core/isc_status_reg.sv
// Sticky write-one-to-clear status register
`timescale 1ns/1ps
module isc_status_reg (
   input wire logic core_clk,
   input wire logic resetn,
   isc_evt_if.holder evt
);

   logic [31:0] sticky_r;
   logic [31:0] sticky_nxt;

   // ----------------------------------------------------------------
   // Update
   // ----------------------------------------------------------------
   // Set applied after clear, so a same-cycle event survives
   assign sticky_nxt = ((sticky_r & ~evt.clear_mask) | evt.set_pulse) & isc_pkg::STATUS_W1C_MASK;

   // PHY bit is a live view, reserved bits read zero
   assign evt.status = sticky_r | ({31'h0, evt.phy_level} << isc_pkg::BIT_PHY);

   // Sticky flops
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         sticky_r <= isc_pkg::STATUS_RESET;
      end else begin
         sticky_r <= sticky_nxt;
      end
   end

endmodule : isc_status_reg

// ===== dv/isc_collector_sva.sv
// Port-level checks on the interrupt status collector
`timescale 1ns/1ps
module isc_collector_sva (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [isc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [isc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [isc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic tx_error,
   input wire logic phy_irq,
   input wire logic power_event,
   input wire logic irq_pending,
   input wire logic irq_pending_holdoff,
   input wire logic irq_power_direct,
   input wire logic low_power
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Decoded accesses
   wire rd_sts = reg_rd && reg_addr == isc_pkg::OFS_STATUS;
   wire wr_sts = reg_wr && reg_addr == isc_pkg::OFS_STATUS;
   wire wr_test = reg_wr && reg_addr == isc_pkg::OFS_BYTE_TEST;
   // Event seen, no write the next cycle, then a status read must show it
   property p_evt(logic ev, int b);
      (ev ##1 !reg_wr ##1 rd_sts) |=> reg_rdata[b];
   endproperty
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside read answer");
   a_phy_live_read: assert property (rd_sts |=> reg_rdata[18] == $past(phy_irq))
      else $error("phy flag does not follow phy input");
   a_reserved_read_zero: assert property (rd_sts |=> (reg_rdata & ~isc_pkg::STATUS_IMPL_MASK) == 32'h0)
      else $error("reserved status bits read nonzero");
   a_pend_split: assert property (irq_pending == (irq_pending_holdoff || irq_power_direct))
      else $error("master indication not union of its parts");
   a_power_sticky: assert property (irq_power_direct && !reg_wr |=> irq_power_direct)
      else $error("power flag dropped without a write");
   a_power_clear: assert property (wr_sts && reg_wdata[17] && !power_event |=> !irq_power_direct)
      else $error("written one did not clear power flag");
   a_stay_asleep: assert property (low_power && !wr_test |=> low_power)
      else $error("left low power without byte test write");
   a_wake_write: assert property (wr_test |=> !low_power)
      else $error("byte test write did not wake");
   a_txerr_flag: assert property (p_evt(tx_error, 13))
      else $error("transmitter error flag missing");
   a_power_flag: assert property (p_evt(power_event, 17))
      else $error("power event flag missing");
   // Main scenarios reached
   c_status_read: cover property (rd_sts);
   c_sleep: cover property ($rose(low_power));
   c_power_direct: cover property (irq_power_direct && !irq_pending_holdoff);
endmodule : isc_collector_sva

// ===== dv/isc_collector_tb.sv
// Self-checking testbench for the interrupt status collector
`timescale 1ns/1ps
module isc_collector_tb;
   logic core_clk, resetn, phy_irq, reg_wr, reg_rd, low_power;
   logic irq_pending, irq_pending_holdoff, irq_power_direct;
   logic [18:0] ev;
   logic [15:0] timer_count;
   logic [7:0] reg_addr;
   logic [31:0] rx_drop_count, reg_wdata, reg_rdata, d;
   int mismatches = 0;
   int checks = 0;
   // Status bit raised by each entry of the event vector
   int evt_bit [19] = '{13, 16, 20, 15, 14, 6, 17, 0, 1, 2, 21, 10, 25, 24, 8, 4, 9, 7, 3};
   // ---------------------------------------------------------------
   // Design and host
   // ---------------------------------------------------------------
   isc_collector uut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_stop_request(ev[12]), .tx_halted(ev[12]),
      .tx_buffer_loaded(ev[10]), .irq_on_completion(1'b1), .tx_error(ev[0]), .tx_data_write(ev[11]),
      .tx_data_full(1'b1), .tx_free_blocks(ev[16] ? 8'h11 : 8'h10), .tx_space_level(8'h10),
      .tx_status_full(ev[14]), .tx_status_overflow(ev[1]), .tx_status_used(ev[17] ? 8'h05 : 8'h04),
      .tx_status_level(8'h04), .rx_halted(ev[13]), .rx_dma_done(ev[2]), .rx_long_frame(ev[3]),
      .rx_error(ev[4]), .rx_frame_dropped(ev[5]), .rx_drop_count(rx_drop_count), .rx_status_full(ev[15]),
      .rx_status_used(ev[18] ? 8'h03 : 8'h02), .rx_status_level(8'h02), .timer_count(timer_count),
      .phy_irq(phy_irq), .power_event(ev[6]), .pin_events(ev[9:7]), .irq_pending(irq_pending),
      .irq_pending_holdoff(irq_pending_holdoff), .irq_power_direct(irq_power_direct), .low_power(low_power));
   isc_host_model h (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Shared checking helpers
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      h.bus_read(a, d);
      chk(name, exp, d);
   endtask : rd_chk
   // One-cycle pulse on one event input
   task automatic pulse(input int i);
      @(posedge core_clk);
      ev[i] <= 1'b1;
      @(posedge core_clk);
      ev[i] <= 1'b0;
   endtask : pulse
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   // Tests take a few hundred cycles; the limit leaves wide margin
   initial begin
      repeat (5000) @(posedge core_clk);
      mismatches++;
      $display("watchdog expired");
      stop_test();
   end
   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      ev = '0;
      phy_irq = 1'b0;
      timer_count = 16'h0005;
      rx_drop_count = 32'h0;
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      rd_chk(isc_pkg::OFS_STATUS, 32'h0, "status reset");
      rd_chk(isc_pkg::OFS_ENABLE, 32'h0, "enable reset");
      rd_chk(8'h40, 32'h0, "unmapped read");
      $display("test reset done");
      // Each of the 19 event inputs, held, kept by zero writes, cleared by ones
      h.bus_write(isc_pkg::OFS_ENABLE, 32'hffff_ffff);
      for (int i = 0; i < 19; i++) begin
         pulse(i);
         #1 chk("pending", {30'h0, 1'b1, (i != 6)}, {30'h0, irq_pending, irq_pending_holdoff});
         rd_chk(isc_pkg::OFS_STATUS, 32'h1 << evt_bit[i], "event flag");
         h.bus_write(isc_pkg::OFS_STATUS, 32'h0);
         rd_chk(isc_pkg::OFS_STATUS, 32'h1 << evt_bit[i], "zero write");
         h.bus_write(isc_pkg::OFS_STATUS, 32'hffff_ffff);
         rd_chk(isc_pkg::OFS_STATUS, 32'h0, "cleared");
      end
      $display("test events done");
      // Masked source still recorded; clear racing an event
      h.bus_write(isc_pkg::OFS_ENABLE, 32'h0);
      pulse(4);
      #1 chk("masked pending", 32'h0, {31'h0, irq_pending});
      rd_chk(isc_pkg::OFS_STATUS, 32'h0000_4000, "masked flag");
      fork
         h.bus_write(isc_pkg::OFS_STATUS, 32'h0000_6000);
         pulse(0);
      join
      rd_chk(isc_pkg::OFS_STATUS, 32'h0000_2000, "set beats clear");
      h.bus_write(isc_pkg::OFS_STATUS, 32'hffff_ffff);
      $display("test mask and race done");
      // Phy flag is live and read-only
      phy_irq <= 1'b1;
      rd_chk(isc_pkg::OFS_STATUS, 32'h0004_0000, "phy live");
      h.bus_write(isc_pkg::OFS_STATUS, 32'h0004_0000);
      rd_chk(isc_pkg::OFS_STATUS, 32'h0004_0000, "phy write");
      phy_irq <= 1'b0;
      rd_chk(isc_pkg::OFS_STATUS, 32'h0, "phy gone");
      // Timer wrap and drop counter midpoint
      @(posedge core_clk);
      timer_count <= 16'h0000;
      rx_drop_count <= 32'h7fff_ffff;
      @(posedge core_clk);
      timer_count <= 16'hffff;
      rx_drop_count <= 32'h8000_0000;
      rd_chk(isc_pkg::OFS_STATUS, 32'h0088_0000, "wrap flags");
      h.bus_write(isc_pkg::OFS_STATUS, 32'hffff_ffff);
      rd_chk(isc_pkg::OFS_STATUS, 32'h0, "wrap cleared");
      $display("test phy and counters done");
      // Software flag re-asserts while its enable stays high
      h.bus_write(isc_pkg::OFS_CONTROL, 32'h1 << isc_pkg::CTL_SW_IRQ_EN);
      h.bus_write(isc_pkg::OFS_STATUS, 32'h8000_0000);
      rd_chk(isc_pkg::OFS_STATUS, 32'h8000_0000, "software held");
      h.bus_write(isc_pkg::OFS_CONTROL, 32'h0);
      h.bus_write(isc_pkg::OFS_STATUS, 32'h8000_0000);
      rd_chk(isc_pkg::OFS_STATUS, 32'h0, "software cleared");
      // Power event leaves the device asleep; byte test write wakes it
      h.bus_write(isc_pkg::OFS_CONTROL, 32'h1 << isc_pkg::CTL_SLEEP_REQ);
      #1 chk("asleep", 32'h1, {31'h0, low_power});
      pulse(6);
      rd_chk(isc_pkg::OFS_STATUS, 32'h0002_0000, "power flag");
      chk("still asleep", 32'h1, {31'h0, low_power});
      rd_chk(isc_pkg::OFS_BYTE_TEST, isc_pkg::BYTE_TEST_VALUE, "byte test");
      h.bus_write(isc_pkg::OFS_BYTE_TEST, 32'h0);
      #1 chk("awake", 32'h0, {31'h0, low_power});
      h.bus_write(isc_pkg::OFS_STATUS, 32'h0002_0000);
      rd_chk(isc_pkg::OFS_STATUS, 32'h0, "power cleared");
      $display("test software and power done");
      stop_test();
   end
endmodule : isc_collector_tb
// Checker attached to the collector
bind isc_collector isc_collector_sva chk_i (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_error(tx_error),
   .phy_irq(phy_irq), .power_event(power_event), .irq_pending(irq_pending),
   .irq_pending_holdoff(irq_pending_holdoff), .irq_power_direct(irq_power_direct), .low_power(low_power));

// ===== dv/isc_host_model.sv
// Host processor model driving the register port
`timescale 1ns/1ps
module isc_host_model (
   input wire logic core_clk,
   output logic [isc_pkg::ADDR_W-1:0] reg_addr,
   output logic [isc_pkg::DATA_W-1:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [isc_pkg::DATA_W-1:0] reg_rdata
);
   // Idle bus from time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One-cycle write; acknowledging flags and waking both use it
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d; // Stale data is not left on the bus
   endtask : bus_write
   // One-cycle read; data stands only in the following cycle
   task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : bus_read
endmodule : isc_host_model
